// ===== rtl/tipt_top.v
// timer pulse-train trigger bit and four-source interrupt logic, axi4-lite slave
// assumes source events and trigger event are pin levels; underflow is same-clock
// assumes the bus master keeps one write and one read outstanding at most
`timescale 1ns/1ps
`default_nettype none
`include "tipt_defines.vh"
module tipt_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [3:0]  source_event,
  input  wire        ext_trigger_event,
  input  wire        second_counter_underflow,
  output reg  [1:0]  timer_mode_select,
  output reg         pulse_train_enable,
  output reg         pulse_select,
  output reg         pulse_train_start,
  output reg         pulse_event_trigger,
  output reg         timer_irq,
  output reg         block_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // pulse-train mode: enable bit set and mode select 00b
  function pt_mode;
    input [1:0] mode;
    input       en;
    begin
      pt_mode = en && (mode == `TIPT_MODE_PULSE);
    end
  endfunction

  // merge byte lanes of a write into an old value
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        // a lane with its strobe low keeps the old byte
        if (st[i]) begin
          lane_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // word address of a byte address: the two low bits never select a register
  function [7:0] word_addr;
    input [7:0] a;
    begin
      word_addr = {a[7:2], 2'h0};
    end
  endfunction

  // one-hot register select: control, pending/enable, clear, status, mask
  function [4:0] reg_sel;
    input [7:0] a;
    begin
      if (a == `TIPT_ADDR_CTRL) begin
        reg_sel = 5'h01;
      end else if (a == `TIPT_ADDR_INT_PE) begin
        reg_sel = 5'h02;
      end else if (a == `TIPT_ADDR_INT_CLR) begin
        reg_sel = 5'h04;
      end else if (a == `TIPT_ADDR_INT_STAT) begin
        reg_sel = 5'h08;
      end else if (a == `TIPT_ADDR_INT_MASK) begin
        reg_sel = 5'h10;
      end else begin
        reg_sel = 5'h00;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  // every source and trigger pin passes two flops before the edge detectors read it
  wire [3:0] src_sync;
  wire [0:0] trig_sync;

  tipt_sync2 #(.W(4)) u_src_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (source_event),
    .q       (src_sync)
  );

  tipt_sync2 #(.W(1)) u_trig_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (ext_trigger_event),
    .q       (trig_sync)
  );

  // rising edge of each synchronised pin; history resets to the idle low level
  reg [3:0] src_prev_r;
  reg       trig_prev_r;
  wire [3:0] src_rise  = src_sync & ~src_prev_r;
  wire       trig_rise = trig_sync[0] & ~trig_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // register state

  // interrupt pending and enable, trigger, event status and mask
  reg [3:0]  pend_r;
  reg [3:0]  pend_nxt;
  reg [3:0]  ien_r;
  reg [1:0]  ev_stat_r;
  reg [1:0]  ev_stat_nxt;
  reg [1:0]  ev_mask_r;
  reg        trig_nxt;

  // write address and data, each held until the other half is in
  reg        aw_held_r;
  reg [7:0]  aw_addr_r;
  reg        w_held_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;

  // a write runs once both halves are held and no response is waiting
  wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;

  // one decode serves both channels; the read side drops the byte offset
  wire [4:0] wr_sel = reg_sel(aw_addr_r);
  wire [4:0] rd_sel = reg_sel(word_addr(s_axi_araddr));
  wire wr_ctrl  = wr_go && wr_sel[0];
  wire wr_pe    = wr_go && wr_sel[1];
  wire wr_clr   = wr_go && wr_sel[2];
  wire wr_mask  = wr_go && wr_sel[4];
  wire rd_stat  = rd_go && rd_sel[3]; // a status read clears it

  // register images and byte-lane merges of the held write
  wire [31:0] ctrl_cur = {21'h000000, pulse_event_trigger, pulse_select, pulse_train_enable,
                          6'h00, timer_mode_select};
  wire [31:0] ctrl_new = lane_merge(ctrl_cur, w_data_r, w_strb_r) & `TIPT_CTRL_MASK;
  wire [31:0] pe_new   = lane_merge({24'h000000, ien_r, pend_r}, w_data_r, w_strb_r);
  wire [31:0] clr_new  = lane_merge(32'h0000_0000, w_data_r, w_strb_r);
  wire [31:0] mask_new = lane_merge({30'h00000000, ev_mask_r}, w_data_r, w_strb_r);

  // mode seen by the trigger logic is the value after a write in this cycle
  wire [1:0] mode_eff = wr_ctrl ? ctrl_new[`TIPT_CTRL_MODE_MSB:`TIPT_CTRL_MODE_LSB] : timer_mode_select;
  wire       en_eff   = wr_ctrl ? ctrl_new[`TIPT_CTRL_PTEN_BIT] : pulse_train_enable;
  wire       sel_eff  = wr_ctrl ? ctrl_new[`TIPT_CTRL_PTSE_BIT] : pulse_select;
  wire       in_pt    = pt_mode(mode_eff, en_eff);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for trigger, pending flags and event status

  // trigger bit: bus write, external edge, underflow; later lines take priority
  always @* begin
    trig_nxt = pulse_event_trigger;
    // in pulse-train mode with select low a write leaves the bit alone
    if (wr_ctrl && !(in_pt && !sel_eff)) begin
      trig_nxt = ctrl_new[`TIPT_CTRL_PTET_BIT];
    end
    // a synchronised external rising edge starts a train when selected
    if (in_pt && sel_eff && trig_rise) begin
      trig_nxt = 1'b1;
    end
    // underflow ends the train and wins over any set
    if (second_counter_underflow) begin
      trig_nxt = 1'b0;
    end
    // outside pulse-train mode the bit has no meaning and stays clear
    if (!in_pt) begin
      trig_nxt = 1'b0;
    end
  end

  // pending: clear by write-one, new event wins over the clear
  always @* begin
    pend_nxt = pend_r;
    if (wr_clr) begin
      pend_nxt = pend_nxt & ~clr_new[3:0];
    end
    pend_nxt = pend_nxt | src_rise;
  end

  // event status: bit0 train started, bit1 train ended; read clears, set wins
  always @* begin
    ev_stat_nxt = ev_stat_r;
    if (rd_stat) begin
      ev_stat_nxt = 2'h0;
    end
    if (trig_nxt && !pulse_event_trigger) begin
      ev_stat_nxt[0] = 1'b1;
    end
    if (pulse_event_trigger && !trig_nxt) begin
      ev_stat_nxt[1] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, interrupt and event registers

  // reset clears every flag, enable and control field
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_select   <= 2'h0;
      pulse_train_enable  <= 1'b0;
      pulse_select        <= 1'b0;
      pulse_event_trigger <= 1'b0;
      pulse_train_start   <= 1'b0;
      pend_r              <= `TIPT_PEND_RESET;
      ien_r               <= `TIPT_IEN_RESET;
      ev_stat_r           <= `TIPT_EV_RESET;
      ev_mask_r           <= 2'h0;
      src_prev_r          <= 4'h0;
      trig_prev_r         <= 1'b0;
      timer_irq           <= 1'b0;
      block_irq           <= 1'b0;
    end else begin
      // edge history for the event detectors
      src_prev_r  <= src_sync;
      trig_prev_r <= trig_sync[0];
      // bus write to the control fields
      if (wr_ctrl) begin
        timer_mode_select  <= ctrl_new[`TIPT_CTRL_MODE_MSB:`TIPT_CTRL_MODE_LSB];
        pulse_train_enable <= ctrl_new[`TIPT_CTRL_PTEN_BIT];
        pulse_select       <= ctrl_new[`TIPT_CTRL_PTSE_BIT];
      end
      // enables only: pending bits are read-only from the bus
      if (wr_pe) begin
        ien_r <= pe_new[7:4];
      end
      if (wr_mask) begin
        ev_mask_r <= mask_new[1:0];
      end
      // trigger bit and a one-cycle start pulse on its rising edge
      pulse_event_trigger <= trig_nxt;
      pulse_train_start   <= trig_nxt && !pulse_event_trigger && in_pt && sel_eff;
      pend_r              <= pend_nxt;
      ev_stat_r           <= ev_stat_nxt;
      // interrupts built from next-state flags so they move with the flags
      timer_irq           <= |(pend_nxt & ien_r);
      block_irq           <= |(ev_stat_nxt & ev_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: capture address and data in either order

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_held_r      <= 1'b0;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TIPT_RESP_OKAY;
    end else begin
      // ready pulses for one cycle, only while its own half is not held and no response is waiting
      s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      // capture each half as it is taken, in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= word_addr(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped or read-only word: data ignored, slverr answered
        if (wr_ctrl || wr_pe || wr_clr || wr_mask) begin
          s_axi_bresp <= `TIPT_RESP_OKAY;
        end else begin
          s_axi_bresp <= `TIPT_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TIPT_RESP_OKAY;
    end else begin
      // arready pulses once per request and never while read data waits
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `TIPT_RESP_OKAY;
        // read mux; the clear register always reads zero
        if (rd_sel[0]) begin
          s_axi_rdata <= ctrl_cur;
        end else if (rd_sel[1]) begin
          s_axi_rdata <= {24'h000000, ien_r, pend_r};
        end else if (rd_sel[2]) begin
          s_axi_rdata <= 32'h0000_0000;
        end else if (rd_sel[3]) begin
          s_axi_rdata <= {30'h00000000, ev_stat_r};
        end else if (rd_sel[4]) begin
          s_axi_rdata <= {30'h00000000, ev_mask_r};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TIPT_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/tipt_defines.vh
// register map, field positions, reset values for the timer pulse-trigger and interrupt block
// assumes an axi4-lite slave with 32-bit data, one aligned word per register
//
// Overview of operation
// - trigger bit set in pulse-train mode with select one starts a pulse train
// - second counter underflow clears the trigger bit, ending the pulse train
// - pulse-train mode with select zero ignores writes to the trigger bit
// - trigger bit reads one while a triggered pulse train runs; resets zero
// - pending flags a to d sit in bits 0..3, read only, reset zero
// - enables a to d sit in bits 4..7, read-write, reset zero
// - writing one to clear-register bits 0..3 clears pending flags a..d
// - pulse-train mode needs enable bit one and mode select 00b
// - select bit nine lets an event trigger pulse trains in pulse-train mode
`ifndef TIPT_DEFINES_VH
`define TIPT_DEFINES_VH

`define TIPT_ADDR_CTRL       8'h18
`define TIPT_ADDR_INT_PE     8'h1c
`define TIPT_ADDR_INT_CLR    8'h20
`define TIPT_ADDR_INT_STAT   8'h24
`define TIPT_ADDR_INT_MASK   8'h28

`define TIPT_CTRL_MODE_LSB   0
`define TIPT_CTRL_MODE_MSB   1
`define TIPT_CTRL_PTEN_BIT   8
`define TIPT_CTRL_PTSE_BIT   9
`define TIPT_CTRL_PTET_BIT   10
`define TIPT_CTRL_MASK       32'h0000_0703

`define TIPT_MODE_PULSE      2'h0
`define TIPT_PEND_RESET      4'h0
`define TIPT_IEN_RESET       4'h0
`define TIPT_EV_RESET        2'h0

`define TIPT_RESP_OKAY       2'h0
`define TIPT_RESP_SLVERR     2'h2

`endif

// ===== rtl/tipt_sync2.v
// two-flop synchroniser for a bundle of pin-level inputs
// assumes inputs come from outside the aclk domain
`timescale 1ns/1ps
`default_nettype none
module tipt_sync2 #(
  parameter W = 4
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;

  // first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;
endmodule
`default_nettype wire

// ===== testbench/tipt_checker.sv
// checker: bus handshakes and trigger-bit relations of tipt_top
// assumes it is bound into tipt_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module tipt_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        second_counter_underflow,
  input wire logic [1:0]  timer_mode_select,
  input wire logic        pulse_train_enable,
  input wire logic        pulse_select,
  input wire logic        pulse_train_start,
  input wire logic        pulse_event_trigger,
  input wire logic        timer_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // trigger bit: start pulse, clearing, gating by select and mode
  trig_start_a: assert property ($rose(pulse_event_trigger) |-> ##[0:1] pulse_train_start)
    else $error("trigger bit rose without a start pulse");
  under_clr_a: assert property (second_counter_underflow |=> !pulse_event_trigger)
    else $error("trigger bit survived an underflow");
  trig_sel_a: assert property ($rose(pulse_event_trigger) |-> pulse_select)
    else $error("trigger bit set while select is low");
  trig_mode_a: assert property (pulse_event_trigger |-> timer_mode_select == 2'h0 && pulse_train_enable)
    else $error("trigger bit set outside pulse-train mode");
  ////////////////////////////////////////////////////////////////////////////////
  // register bus: responses hold until taken, bounded latency
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  // main scenarios reached
  cover property (pulse_train_start);
  cover property (timer_irq);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind tipt_top tipt_checker i_tipt_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .second_counter_underflow, .timer_mode_select, .pulse_train_enable, .pulse_select, .pulse_train_start,
  .pulse_event_trigger, .timer_irq);
`default_nettype wire

// ===== testbench/tipt_top_tb.sv
// bench: drives tipt_top over axi4-lite and its event pins, judges each scenario
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tipt_top_tb;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hf, source_event = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        ext_trigger_event = 0, second_counter_underflow = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, timer_mode_select;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        pulse_train_enable, pulse_select, pulse_train_start, pulse_event_trigger, timer_irq, block_irq;
  int          error_cnt = 0, n_tests = 0, n_start = 0;
  tipt_top i_tipt_top (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // clock and start-pulse catcher
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    if (pulse_train_start) n_start <= n_start + 1;
  end
  // one bus transfer: request held until taken, ready raised late to stall the answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ak, dk, rk;
    logic [1:0] rs;
    n = 0;
    rk = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    while (!rk && n < 40) begin
      @(negedge aclk);
      ak = w ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
      dk = s_axi_wvalid & s_axi_wready;
      rk = w ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
      rs = w ? s_axi_bresp : s_axi_rresp;
      rdat = s_axi_rdata;
      n++;
      @(posedge aclk);
      if (ak) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (dk) s_axi_wvalid <= 1'b0;
      if (n == 3) begin
        s_axi_bready <= w;
        s_axi_rready <= !w;
      end
      if (rk) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
    `CHK(rk, 1'b1)
    `CHK(rs, er)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 2'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 2'h0);
    `CHK(rdat, e)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_reset;
    rd(8'h1c, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h20, 32'h0);
    bus(1'b0, 8'h40, 32'h0, 2'h2);
    `CHK(rdat, 32'h0)
    bus(1'b1, 8'h40, 32'h1, 2'h2);
  endtask
  task t_irq;
    wr(8'h1c, 32'hff);
    rd(8'h1c, 32'hf0);
    for (int i = 0; i < 4; i++) begin
      source_event <= 4'h1 << i;
      repeat (6) @(posedge aclk);
      rd(8'h1c, 32'hf0 | (32'h1 << i));
      @(negedge aclk);
      `CHK(timer_irq, 1'b1)
      @(posedge aclk);
      source_event <= 4'h0;
      wr(8'h20, 32'h1 << i);
      rd(8'h1c, 32'hf0);
      @(negedge aclk);
      `CHK(timer_irq, 1'b0)
    end
    wr(8'h1c, 32'he0);
    source_event <= 4'h1;
    repeat (6) @(posedge aclk);
    rd(8'h1c, 32'he1);
    @(negedge aclk);
    `CHK(timer_irq, 1'b0)
    wr(8'h20, 32'h1);
    source_event <= 4'h0;
    rd(8'h1c, 32'he0);
  endtask
  task t_trig;
    int k;
    wr(8'h28, 32'h3);
    rd(8'h28, 32'h3);
    wr(8'h18, 32'h300);
    k = n_start;
    wr(8'h18, 32'h700);
    rd(8'h18, 32'h700);
    `CHK(n_start - k, 1)
    @(negedge aclk);
    `CHK(block_irq, 1'b1)
    rd(8'h24, 32'h1);
    second_counter_underflow <= 1'b1;
    @(posedge aclk);
    second_counter_underflow <= 1'b0;
    rd(8'h18, 32'h300);
    rd(8'h24, 32'h2);
    repeat (2) @(negedge aclk);
    `CHK(block_irq, 1'b0)
    wr(8'h28, 32'h0);
    ext_trigger_event <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(8'h18, 32'h700);
    `CHK(n_start - k, 2)
    @(negedge aclk);
    `CHK(block_irq, 1'b0)
    rd(8'h24, 32'h1);
    ext_trigger_event <= 1'b0;
    second_counter_underflow <= 1'b1;
    @(posedge aclk);
    second_counter_underflow <= 1'b0;
    rd(8'h18, 32'h300);
  endtask
  task t_mode;
    logic [31:0] cfg [4];
    cfg = '{32'h301, 32'h302, 32'h303, 32'h200};
    foreach (cfg[i]) begin
      wr(8'h18, cfg[i]);
      wr(8'h18, cfg[i] | 32'h400);
      rd(8'h18, cfg[i]);
      `CHK({pulse_select, pulse_train_enable, timer_mode_select}, {cfg[i][9:8], cfg[i][1:0]})
    end
    wr(8'h18, 32'h100);
    wr(8'h18, 32'h500);
    ext_trigger_event <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(8'h18, 32'h100);
    ext_trigger_event <= 1'b0;
    rd(8'h27, 32'h2);
    rd(8'h24, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // verdict, main sequence, watchdog
  task give_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_irq;
    t_trig;
    t_mode;
    give_verdict;
  end
  initial begin
    #40000;
    error_cnt++;
    give_verdict;
  end
endmodule
`default_nettype wire
